// >>> hw/usc_ctrl.sv
// Behaviour
// - Transmit request follows empty flag when enabled
// - Receive interrupt enable raises data and fault requests
// - Receive interrupt enable low masks all receive requests
// - Receive requests drop on read-one-write-zero
// - Transmitter starts only once FIFO holds data
// - Receiver starts on detected start bit
// - Clearing receive enable keeps receive flags
// - Reserved bits read zero, written zero
// - Clock field selects source and pin direction
// - Output enable bit matters only internally
// - Driven pin clock runs at 16x bit rate
// - Transmit enable gates start, not empty-flag request
// - Control register always readable and writable
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module usc_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_tx_below_trig,
  input wire logic i_tx_fifo_has_data,
  input wire logic i_rx_above_trig,
  input wire logic i_rx_ready_evt,
  input wire logic i_rx_err_evt,
  input wire logic i_break_evt,
  input wire logic i_framing_fault,
  input wire logic i_parity_fault,
  input wire logic i_rx_line,
  input wire logic i_sclk_in,
  output logic o_sclk_out,
  output logic o_sclk_oe,
  output logic o_tick16,
  output logic o_tx_go,
  output logic o_rx_start,
  output logic o_tx_en,
  output logic o_rx_en,
  output logic o_tx_fifo_irq,
  output logic o_rx_data_irq,
  output logic o_rx_fault_irq,
  output logic o_break_irq
);

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // Bus handshake: one wait cycle per access
  logic req;
  logic ack_r;
  logic ack_nxt;
  logic done;
  logic wr_lane0;
  logic ctrl_wr;
  logic stat_rd;
  logic stat_wr;
  logic div_wr;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Registers
  localparam int NFLAG_W = usc_pkg::NFLAG;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [NFLAG_W-1:0] flag_r;
  logic [NFLAG_W-1:0] flag_nxt;
  logic [NFLAG_W-1:0] arm_r;
  logic [NFLAG_W-1:0] arm_nxt;
  logic [NFLAG_W-1:0] flag_set;

  // Pin synchronisers and line state
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  logic ck_s1_r;
  logic ck_s2_r;
  logic ck_prev_r;

  // Registered outputs
  logic rx_start_r;
  logic rx_start_nxt;
  logic tx_go_r;
  logic tx_go_nxt;
  logic tick_r;
  logic tick_nxt;
  logic oe_r;
  logic oe_nxt;
  logic tx_irq_r;
  logic rxd_irq_r;
  logic rxf_irq_r;
  logic brk_irq_r;
  logic [3:0] irq_nxt;

  logic ext_clk;
  logic int_tick;
  logic int_clk;

  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  assign done = req & ack_r;
  assign wr_lane0 = done & i_avs_write & i_avs_byteenable[0];
  assign ctrl_wr = wr_lane0 & hit(i_avs_address, usc_pkg::CTRL_OFS);
  assign stat_wr = wr_lane0 & hit(i_avs_address, usc_pkg::STAT_OFS);
  assign div_wr = wr_lane0 & hit(i_avs_address, usc_pkg::DIV_OFS);
  assign stat_rd = done & i_avs_read & hit(i_avs_address, usc_pkg::STAT_OFS);

  // Bus answer and read data
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (req && !ack_r && i_avs_read) begin
      if (hit(i_avs_address, usc_pkg::CTRL_OFS)) begin
        rdata_nxt = {24'h00_0000, ctrl_r};
      end else if (hit(i_avs_address, usc_pkg::STAT_OFS)) begin
        rdata_nxt = {25'h000_0000, i_parity_fault, i_framing_fault, flag_r};
      end else if (hit(i_avs_address, usc_pkg::DIV_OFS)) begin
        rdata_nxt = {24'h00_0000, div_r};
      end else begin
        rdata_nxt = usc_pkg::UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

  // Control and divider registers; reserved bits are stored as zero
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    if (ctrl_wr) begin
      ctrl_nxt = i_avs_writedata[7:0] & usc_pkg::CTRL_WMASK;
    end
    if (div_wr) begin
      div_nxt = i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_r <= usc_pkg::CTRL_RST;
      div_r <= usc_pkg::DIV_RST;
    end else if (i_ce) begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
    end
  end

  assign o_tx_en = ctrl_r[usc_pkg::TX_EN_BIT];
  assign o_rx_en = ctrl_r[usc_pkg::RX_EN_BIT];

  // Flag set sources; level sources keep their flag set while active
  assign flag_set[usc_pkg::TX_EMPTY_BIT] = i_tx_below_trig;
  assign flag_set[usc_pkg::RX_FULL_BIT] = i_rx_above_trig;
  assign flag_set[usc_pkg::RX_READY_BIT] = i_rx_ready_evt;
  assign flag_set[usc_pkg::RX_FAULT_BIT] = i_rx_err_evt;
  assign flag_set[usc_pkg::BREAK_BIT] = i_break_evt;

  // Each flag clears only by a zero write after being read as one; set wins
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG_W; gi = gi + 1) begin : g_flag
      always_comb begin
        arm_nxt[gi] = arm_r[gi];
        flag_nxt[gi] = flag_r[gi];
        if (stat_wr && arm_r[gi] && !i_avs_writedata[gi]) begin
          flag_nxt[gi] = 1'b0;
        end
        if (stat_wr) begin
          arm_nxt[gi] = 1'b0;
        end
        if (stat_rd && flag_r[gi]) begin
          arm_nxt[gi] = 1'b1;
        end
        if (flag_set[gi]) begin
          flag_nxt[gi] = 1'b1;
        end
        if (!flag_nxt[gi]) begin
          arm_nxt[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag_r <= usc_pkg::FLAG_RST;
      arm_r <= usc_pkg::FLAG_RST;
    end else if (i_ce) begin
      flag_r <= flag_nxt;
      arm_r <= arm_nxt;
    end
  end

  // Interrupt requests
  always_comb begin
    irq_nxt[0] = ctrl_r[usc_pkg::TX_IRQ_EN_BIT] & flag_r[usc_pkg::TX_EMPTY_BIT];
    irq_nxt[1] = ctrl_r[usc_pkg::RX_IRQ_EN_BIT]
                 & (flag_r[usc_pkg::RX_FULL_BIT] | flag_r[usc_pkg::RX_READY_BIT]);
    irq_nxt[2] = ctrl_r[usc_pkg::RX_IRQ_EN_BIT] & flag_r[usc_pkg::RX_FAULT_BIT];
    irq_nxt[3] = ctrl_r[usc_pkg::RX_IRQ_EN_BIT] & flag_r[usc_pkg::BREAK_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_irq_r <= 1'b0;
      rxd_irq_r <= 1'b0;
      rxf_irq_r <= 1'b0;
      brk_irq_r <= 1'b0;
    end else if (i_ce) begin
      tx_irq_r <= irq_nxt[0];
      rxd_irq_r <= irq_nxt[1];
      rxf_irq_r <= irq_nxt[2];
      brk_irq_r <= irq_nxt[3];
    end
  end

  assign o_tx_fifo_irq = tx_irq_r;
  assign o_rx_data_irq = rxd_irq_r;
  assign o_rx_fault_irq = rxf_irq_r;
  assign o_break_irq = brk_irq_r;

  // Clock source selection
  assign ext_clk = ctrl_r[usc_pkg::CLK_SRC_BIT];

  usc_baud_gen u_baud (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_run(~ext_clk),
    .i_div(div_r),
    .o_tick(int_tick),
    .o_clk(int_clk)
  );

  assign o_sclk_out = int_clk;

  // Transmit start, receive start and 16x tick
  always_comb begin
    tx_go_nxt = ctrl_r[usc_pkg::TX_EN_BIT] & i_tx_fifo_has_data;
    rx_start_nxt = ctrl_r[usc_pkg::RX_EN_BIT] & rx_prev_r & ~rx_s2_r;
    oe_nxt = ~ext_clk & ~ctrl_r[usc_pkg::CLK_OUT_BIT];
    if (ext_clk) begin
      tick_nxt = ck_s2_r & ~ck_prev_r;
    end else begin
      tick_nxt = int_tick;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_prev_r <= 1'b0;
      tx_go_r <= 1'b0;
      rx_start_r <= 1'b0;
      oe_r <= 1'b0;
      tick_r <= 1'b0;
    end else if (i_ce) begin
      rx_s1_r <= i_rx_line;
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
      ck_s1_r <= i_sclk_in;
      ck_s2_r <= ck_s1_r;
      ck_prev_r <= ck_s2_r;
      tx_go_r <= tx_go_nxt;
      rx_start_r <= rx_start_nxt;
      oe_r <= oe_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tx_go = tx_go_r;
  assign o_rx_start = rx_start_r;
  assign o_sclk_oe = oe_r;
  assign o_tick16 = tick_r;

  // Checks
  sequence s_fault_read_one;
    i_ce && stat_rd && flag_r[usc_pkg::RX_FAULT_BIT];
  endsequence
  sequence s_fault_write_zero;
    i_ce && stat_wr && !i_avs_writedata[usc_pkg::RX_FAULT_BIT] && !i_rx_err_evt;
  endsequence
  sequence s_start_edge;
    (i_ce && i_rx_line) [*3] ##1 (i_ce && !i_rx_line) [*3];
  endsequence

  a_tx_irq_raise: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ctrl_r[usc_pkg::TX_IRQ_EN_BIT] && flag_r[usc_pkg::TX_EMPTY_BIT] |=> o_tx_fifo_irq)
    else $error("Transmit request not raised");
  a_tx_irq_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !ctrl_r[usc_pkg::TX_IRQ_EN_BIT] |=> !o_tx_fifo_irq)
    else $error("Transmit request not masked");
  a_rx_irq_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !ctrl_r[usc_pkg::RX_IRQ_EN_BIT] |=> !(o_rx_data_irq || o_rx_fault_irq || o_break_irq))
    else $error("Receive request not masked");
  a_rx_data_raise: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ctrl_r[usc_pkg::RX_IRQ_EN_BIT] && flag_r[usc_pkg::RX_FULL_BIT] |=> o_rx_data_irq)
    else $error("Receive data request not raised");
  // Two-cycle accesses: the next completed access is two or three cycles on
  a_fault_clear_seq: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_fault_read_one ##[2:3] s_fault_write_zero |=> !flag_r[usc_pkg::RX_FAULT_BIT])
    else $error("Fault flag not cleared after read and zero write");
  a_fault_needs_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && stat_wr && !arm_r[usc_pkg::RX_FAULT_BIT] && flag_r[usc_pkg::RX_FAULT_BIT]
    |=> flag_r[usc_pkg::RX_FAULT_BIT])
    else $error("Fault flag cleared without prior read");
  a_empty_set_wins: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_tx_below_trig |=> flag_r[usc_pkg::TX_EMPTY_BIT])
    else $error("Empty flag lost while below trigger");
  a_ctrl_keeps_flags: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ctrl_wr && !stat_wr |=> flag_r == ($past(flag_r) | $past(flag_set)))
    else $error("Control write disturbed flags");
  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    done && i_avs_read && hit(i_avs_address, usc_pkg::CTRL_OFS) |-> o_avs_readdata[3:2] == 2'b00)
    else $error("Reserved bits read nonzero");
  a_pin_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ctrl_r[1:0] == 2'b00 |=> o_sclk_oe)
    else $error("Clock pin not driven for internal output");
  a_ext_no_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ctrl_r[usc_pkg::CLK_SRC_BIT] |=> !o_sclk_oe)
    else $error("Clock pin driven with external source");
  a_tx_go_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && !ctrl_r[usc_pkg::TX_EN_BIT] |=> !o_tx_go)
    else $error("Transmit started while disabled");
  a_rx_start_det: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_start_edge ##0 ctrl_r[usc_pkg::RX_EN_BIT] |=> o_rx_start)
    else $error("Start bit not detected");

endmodule : usc_ctrl

`default_nettype wire

// >>> hw/usc_pkg.sv
package usc_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DIV_OFS = 4'h8;

  // Serial control field positions
  localparam int TX_IRQ_EN_BIT = 7;
  localparam int RX_IRQ_EN_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int CLK_SRC_BIT = 1;
  localparam int CLK_OUT_BIT = 0;

  // Control register reset value and writable bits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;

  // Status flag positions
  localparam int NFLAG = 5;
  localparam int TX_EMPTY_BIT = 0;
  localparam int RX_FULL_BIT = 1;
  localparam int RX_READY_BIT = 2;
  localparam int RX_FAULT_BIT = 3;
  localparam int BREAK_BIT = 4;
  localparam int FRAME_FLT_BIT = 5;
  localparam int PARITY_FLT_BIT = 6;
  localparam logic [NFLAG-1:0] FLAG_RST = 5'h00;

  // Divider for the 16x serial clock
  localparam logic [7:0] DIV_RST = 8'h0F;

  // Bus answer for unmapped reads
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage : usc_pkg

// >>> hw/usc_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none

module usc_baud_gen (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [7:0] i_div,
  output logic o_tick,
  output logic o_clk
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic clk_r;
  logic clk_nxt;

  // Period of i_div+1 cycles per 16x clock, high for the first half
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    clk_nxt = 1'b0;
    if (i_run) begin
      if (cnt_r >= i_div) begin
        cnt_nxt = 8'h00;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
      clk_nxt = (cnt_nxt <= {1'b0, i_div[7:1]});
    end else begin
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
      clk_r <= 1'b0;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign o_tick = tick_r;
  assign o_clk = clk_r;

endmodule : usc_baud_gen

`default_nettype wire

// >>> testbench/usc_remote_dev.sv
`timescale 1ns/100ps
`default_nettype none

module usc_remote_dev (
  input wire logic i_core_clk,
  input wire logic i_clk_run,
  input wire logic i_send,
  output logic o_rx_line,
  output logic o_sclk
);
  logic [4:0] cnt_r;
  logic [4:0] low_r;

  initial begin
    cnt_r = 5'h00;
    low_r = 5'h00;
    o_rx_line = 1'b1;
    o_sclk = 1'b0;
  end

  // External 16x clock, eight core cycles a period, still when not running
  always @(posedge i_core_clk) begin
    cnt_r <= i_clk_run ? cnt_r + 5'h01 : 5'h00;
    o_sclk <= i_clk_run & cnt_r[2];
  end

  // Start bit: line low for sixteen cycles, then back to idle high
  always @(posedge i_core_clk) begin
    low_r <= i_send ? 5'h10 : ((low_r != 5'h00) ? low_r - 5'h01 : 5'h00);
    o_rx_line <= ~(i_send | (low_r > 5'h01));
  end
endmodule : usc_remote_dev

`default_nettype wire

// >>> testbench/usc_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module usc_ctrl_tb;
  logic clk, rst, rd_s, wr_s, tx_below, has_data, rx_above, rdy_evt, err_evt, break_ev, frm_f, par_f;
  logic clk_run, send, rx_line, rem_sclk, sclk_pin, sclk_out, sclk_oe, tick16, tx_go, rx_start;
  logic tx_en_o, rx_en_o, irq_tx, irq_rx, irq_flt, irq_bk, wreq, pin_q, ce;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata;
  int err_total, checks_done, ticks, pins, starts;

  assign sclk_pin = sclk_oe ? sclk_out : (clk_run ? rem_sclk : 1'b1);

  usc_ctrl dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_avs_address(addr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_tx_below_trig(tx_below), .i_tx_fifo_has_data(has_data),
    .i_rx_above_trig(rx_above), .i_rx_ready_evt(rdy_evt), .i_rx_err_evt(err_evt), .i_break_evt(break_ev),
    .i_framing_fault(frm_f), .i_parity_fault(par_f), .i_rx_line(rx_line), .i_sclk_in(sclk_pin),
    .o_sclk_out(sclk_out), .o_sclk_oe(sclk_oe), .o_tick16(tick16), .o_tx_go(tx_go),
    .o_rx_start(rx_start), .o_tx_en(tx_en_o), .o_rx_en(rx_en_o), .o_tx_fifo_irq(irq_tx),
    .o_rx_data_irq(irq_rx), .o_rx_fault_irq(irq_flt), .o_break_irq(irq_bk));

  usc_remote_dev remote (.i_core_clk(clk), .i_clk_run(clk_run), .i_send(send), .o_rx_line(rx_line),
    .o_sclk(rem_sclk));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse and edge counts, sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (tick16 === 1'b1) ticks++;
    if (rx_start === 1'b1) starts++;
    if (sclk_pin === 1'b1 && pin_q === 1'b0) pins++;
    pin_q = sclk_pin;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    be <= 4'hF;
    wr_s <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdata;
    rd_s <= 1'b0;
  endtask : rd

  task automatic chr(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, d, {24'h000000, e});
  endtask : chr

  task automatic final_report;
    $display("Counts: checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #400000;
    err_total++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    int t0, p0, s0;
    {rst, rd_s, wr_s, tx_below, has_data, rx_above, rdy_evt, err_evt, break_ev} = 9'h100;
    {frm_f, par_f, clk_run, send, pin_q, ce} = 6'h01;
    {addr, be, wdata} = 40'h0;
    {err_total, checks_done, ticks, pins, starts} = 0;
    cyc(20);
    rst <= 1'b0;
    chr("ctrl_reset", usc_pkg::CTRL_OFS, 8'h00);
    chr("unmapped", 4'hC, 8'h00);
    wr(usc_pkg::CTRL_OFS, 8'hFF);
    chr("ctrl_reserved", usc_pkg::CTRL_OFS, 8'hF3);
    wr(usc_pkg::DIV_OFS, 8'h03);
    for (int m = 0; m < 4; m++) begin
      clk_run <= m[1];
      wr(usc_pkg::CTRL_OFS, m[7:0]);
      cyc(20);
      t0 = ticks;
      p0 = pins;
      cyc(80);
      chk("pin_drive", {31'h0, sclk_oe}, (m == 0) ? 32'h1 : 32'h0);
      chk("tick_count", ticks - t0, m[1] ? 32'd10 : 32'd20);
      chk("pin_clock", pins - p0, (m == 0) ? 32'd20 : (m[1] ? 32'd10 : 32'd0));
    end
    clk_run <= 1'b0;
    wr(usc_pkg::CTRL_OFS, 8'h00);
    tx_below <= 1'b1;
    cyc(4);
    chk("tx_irq_masked", irq_tx, 0);
    wr(usc_pkg::CTRL_OFS, 8'h80);
    cyc(3);
    chk("tx_irq_on", irq_tx, 1);
    wr(usc_pkg::CTRL_OFS, 8'h00);
    cyc(3);
    chk("tx_irq_disable", irq_tx, 0);
    wr(usc_pkg::CTRL_OFS, 8'h80);
    tx_below <= 1'b0;
    cyc(3);
    chk("tx_irq_held", irq_tx, 1);
    rd(usc_pkg::STAT_OFS, d);
    chk("tx_empty_flag", d, 32'h01);
    wr(usc_pkg::STAT_OFS, 8'h00);
    cyc(3);
    chk("tx_irq_cleared", irq_tx, 0);
    {rdy_evt, err_evt, break_ev} <= 3'b111;
    cyc(1);
    {rdy_evt, err_evt, break_ev} <= 3'b000;
    cyc(3);
    chk("rx_irqs_masked", {irq_rx, irq_flt, irq_bk}, 0);
    wr(usc_pkg::STAT_OFS, 8'h00);
    wr(usc_pkg::CTRL_OFS, 8'h50);
    cyc(3);
    chk("rx_irqs_on", {irq_rx, irq_flt, irq_bk}, 3'b111);
    {frm_f, par_f} <= 2'b11;
    wr(usc_pkg::CTRL_OFS, 8'h40);
    chr("rx_flags_kept", usc_pkg::STAT_OFS, 8'h7C);
    {frm_f, par_f} <= 2'b00;
    wr(usc_pkg::CTRL_OFS, 8'h00);
    cyc(3);
    chk("rx_irqs_disable", {irq_rx, irq_flt, irq_bk}, 0);
    wr(usc_pkg::CTRL_OFS, 8'h40);
    rd(usc_pkg::STAT_OFS, d);
    wr(usc_pkg::STAT_OFS, 8'h00);
    cyc(3);
    chk("rx_irqs_cleared", {irq_rx, irq_flt, irq_bk}, 0);
    rx_above <= 1'b1;
    cyc(3);
    chk("rx_full_irq", irq_rx, 1);
    rx_above <= 1'b0;
    rd(usc_pkg::STAT_OFS, d);
    wr(usc_pkg::STAT_OFS, 8'h00);
    cyc(3);
    chk("rx_full_cleared", irq_rx, 0);
    wr(usc_pkg::CTRL_OFS, 8'h20);
    cyc(3);
    chk("tx_idle", {tx_en_o, tx_go}, 2'b10);
    has_data <= 1'b1;
    cyc(3);
    chk("tx_start", tx_go, 1);
    ce <= 1'b0;
    has_data <= 1'b0;
    cyc(3);
    chk("ce_freeze", tx_go, 1);
    ce <= 1'b1;
    cyc(3);
    chk("tx_stop", tx_go, 0);
    wr(usc_pkg::CTRL_OFS, 8'h00);
    s0 = starts;
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(30);
    chk("rx_start_off", starts - s0, 0);
    wr(usc_pkg::CTRL_OFS, 8'h10);
    cyc(5);
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(30);
    chk("rx_start_on", {rx_en_o, 31'(starts - s0)}, 32'h80000001);
    final_report();
  end
endmodule : usc_ctrl_tb

`default_nettype wire
